// [hw/wpb_pkg.sv]
/*
  Shared types and constants for the waveform playback engine: sample
  layout, marker bit positions, trigger modes, timing counts, BER setup.
  Assumes a single 50 MHz system clock domain.
*/
package wpb_pkg;

  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 20000;
  localparam int SLOW_LAT_NS     = 220;
  localparam int SLOW_LAT_CYC    = (SLOW_LAT_NS * 1000) / CLK_PERIOD_PS;
  localparam int FAST_LAT_SAMP   = 11;
  localparam int SKEW_STEP_PS    = 10;
  localparam int SKEW_MAX_STEPS  = 100;

  // --------------------------------------------------------------------
  // sample layout
  // --------------------------------------------------------------------
  localparam int WORD_W          = 16;
  localparam int MRK_LO_BIT      = 0;
  localparam int MRK_HI_BIT      = 1;
  localparam int ADDR_W          = 10;
  localparam int RATE_W          = 32;
  localparam int MIN_LEN         = 24;

  // --------------------------------------------------------------------
  // bit error checker
  // --------------------------------------------------------------------
  localparam int PRBS_W          = 23;
  localparam int CNT_W           = 32;

  typedef struct packed {
    logic [WORD_W-1:0] i_word;
    logic [WORD_W-1:0] q_word;
  } wpb_sample_t;

  typedef enum logic [1:0] {
    TRIG_OFF,
    TRIG_SINGLE,
    TRIG_PLAYBACK_MODE_A,
    TRIG_REPEAT
  } wpb_trig_mode_t;

  typedef enum logic [1:0] {
    PRBS_7,
    PRBS_9,
    PRBS_15,
    PRBS_23
  } wpb_prbs_sel_t;

endpackage : wpb_pkg

// [hw/wpb_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module wpb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clear) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : wpb_fifo

// [hw/wpb_playback.sv]
/*
  Waveform playback engine: sample fetch, markers, trigger modes,
  clock output, I/Q skew and the bit error checker.
  Assumes the waveform memory answers a read one cycle after the address
  and that the controller loads length, idle value and setup ports.
*/
// Summary of operation
// - each memory word holds I and Q, read together per sample
// - marker 1 is I bit 0, marker 2 is I bit 1
// - marker 3 is Q bit 0, marker 4 is Q bit 1
// - markers come from loaded waveform data, no separate programming
// - markers may be shifted in time against the I/Q samples
// - rear routing: markers 3 and 4 carry the Q and I sign bits instead
// - clock output is a square wave at the programmed sample rate
// - clock output stays inactive while stopped
// - start by command or trigger input, edge or level, selectable sense
// - repeat mode wraps from last to first sample without gap
// - single mode plays one pass then goes idle
// - playback_mode_a mode with level sense plays while trigger lasts, restarts at first sample
// - off mode stops playback at once and outputs idle
// - idle value shown before trigger and after each trigger ends
// - slow mode starts playback 220 ns after the trigger
// - fast mode starts playback 11 samples after the trigger
// - skew -1.0 to +1.0, positive delays I against Q
// - checker locks onto PRBS from bit clock and data, counts errors
// - checker polarity, polynomial, integration time configurable
// - checker runs independently of playback
// - slow below 2 MHz, fast above 4 MHz, either between
// - restart input high holds measurement reset, low lets it run
// - bits count only while bit_valid_input is active
`timescale 1ns/1ps
module wpb_playback
  import wpb_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int MAX_SHIFT  = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // waveform memory read port
  output logic        [ADDR_W-1:0]    mem_addr,
  output logic                        mem_rd,
  input  wire wpb_pkg::wpb_sample_t   mem_data,
  // setup
  input  wire logic        [ADDR_W-1:0] wave_len,
  input  wire wpb_pkg::wpb_sample_t   idle_value,
  input  wire wpb_pkg::wpb_trig_mode_t trig_mode,
  input  wire logic                   trig_level_sens,
  input  wire logic                   trig_active_low,
  input  wire logic                   cmd_trigger,
  input  wire logic                   fast_mode,
  input  wire logic        [RATE_W-1:0] rate_step,
  input  wire logic signed [7:0]      skew_steps,
  input  wire logic        [4:0]      marker_shift [4],
  input  wire logic                   rear_routing,
  input  wire logic                   ext_trigger,
  // outputs
  output wpb_pkg::wpb_sample_t        iq_out,
  output logic        [3:0]           marker_out,
  output logic                        clock_out,
  output logic                        running,
  output logic signed [7:0]           skew_i_steps,
  output logic signed [7:0]           skew_q_steps,
  // bit error checker
  input  wire logic                   ber_clk_in,
  input  wire logic                   ber_data_in,
  input  wire logic                   bit_valid_input,
  input  wire logic                   checker_restart_input,
  input  wire logic                   ber_clk_inv,
  input  wire logic                   ber_data_inv,
  input  wire logic                   ber_valid_low,
  input  wire wpb_pkg::wpb_prbs_sel_t ber_poly,
  input  wire logic        [CNT_W-1:0] ber_int_bits,
  output logic        [CNT_W-1:0]     ber_bit_count,
  output logic        [CNT_W-1:0]     ber_err_count,
  output logic                        ber_locked,
  output logic                        ber_done
);

  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_PLAY} wpb_state_t;

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic [1:0] trg_sync_q;
  logic [1:0] bclk_sync_q;
  logic [1:0] bdat_sync_q;
  logic [1:0] bval_sync_q;
  logic [1:0] bres_sync_q;

  // two flops per external pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trg_sync_q  <= '0;
      bclk_sync_q <= '0;
      bdat_sync_q <= '0;
      bval_sync_q <= '0;
      bres_sync_q <= 2'h3;
    end else begin
      trg_sync_q  <= {trg_sync_q[0], ext_trigger};
      bclk_sync_q <= {bclk_sync_q[0], ber_clk_in};
      bdat_sync_q <= {bdat_sync_q[0], ber_data_in};
      bval_sync_q <= {bval_sync_q[0], bit_valid_input};
      bres_sync_q <= {bres_sync_q[0], checker_restart_input};
    end
  end

  // --------------------------------------------------------------------
  // sample rate generator
  // --------------------------------------------------------------------
  logic [RATE_W-1:0] phase_q;
  logic              samp_tick_q;
  logic [RATE_W:0]   phase_sum;

  assign phase_sum = {1'b0, phase_q} + {1'b0, rate_step};

  // phase accumulator, one tick per sample period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q     <= '0;
      samp_tick_q <= 1'b0;
    end else begin
      phase_q     <= phase_sum[RATE_W-1:0];
      samp_tick_q <= phase_sum[RATE_W];
    end
  end

  // --------------------------------------------------------------------
  // trigger detection
  // --------------------------------------------------------------------
  logic trg_lvl;
  logic trg_prev_q;
  logic trg_edge;

  assign trg_lvl  = trg_sync_q[1] ^ trig_active_low;
  assign trg_edge = trg_lvl && !trg_prev_q;

  // previous level for edge sensing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trg_prev_q <= 1'b0;
    end else begin
      trg_prev_q <= trg_lvl;
    end
  end

  logic trg_event;
  logic gate_on;
  assign trg_event = cmd_trigger ||
                     (trig_level_sens ? trg_lvl : trg_edge);
  assign gate_on   = trig_level_sens ? trg_lvl : 1'b1;

  // --------------------------------------------------------------------
  // playback state machine
  // --------------------------------------------------------------------
  wpb_state_t      state_q;
  logic [15:0]     lat_q;
  logic [ADDR_W-1:0] addr_q;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  wpb_sample_t     fifo_out_data;
  logic            rd_pend_q;
  logic            last_q;
  logic            flush;
  logic            play_pop;

  assign flush    = (state_q != ST_PLAY);
  assign play_pop = (state_q == ST_PLAY) && samp_tick_q;

  // start latency, stop conditions, sample addressing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_STOP;
      lat_q   <= '0;
      addr_q  <= '0;
    end else begin
      case (state_q)
        ST_STOP: begin
          addr_q <= '0;
          if (trig_mode != TRIG_OFF && trg_event) begin
            state_q <= ST_WAIT;
            // slow: fixed ns delay, fast: sample count
            lat_q <= fast_mode ? 16'(FAST_LAT_SAMP)
                               : 16'(SLOW_LAT_CYC);
          end
        end
        ST_WAIT: begin
          if (trig_mode == TRIG_OFF) begin
            state_q <= ST_STOP;
          end else if (!fast_mode || samp_tick_q) begin
            if (lat_q <= 16'h0001) begin
              state_q <= ST_PLAY;
            end
            lat_q <= lat_q - 16'h0001;
          end
        end
        ST_PLAY: begin
          if (trig_mode == TRIG_OFF) begin
            state_q <= ST_STOP;
          end else if (trig_mode == TRIG_PLAYBACK_MODE_A && !gate_on) begin
            state_q <= ST_STOP;
          end else if (trig_mode == TRIG_SINGLE && play_pop && last_q
                       && fifo_out_valid) begin
            state_q <= ST_STOP;
          end
          if (mem_rd) begin
            // repeat and playback_mode_a wrap with no gap
            addr_q <= (addr_q == wave_len - 1'b1) ? '0
                                                  : addr_q + 1'b1;
          end
        end
        default: state_q <= ST_STOP;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // memory fetch into the sample FIFO
  // --------------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr_q;

  // prefetch both words together while FIFO has room
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rd    <= 1'b0;
      mem_addr  <= '0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      mem_rd    <= (state_q == ST_PLAY) && fifo_in_ready && !mem_rd
                   && !rd_pend_q;
      mem_addr  <= addr_q;
      rd_pend_q <= mem_rd && !flush;
      rd_addr_q <= mem_addr;
    end
  end

  logic fifo_last;
  logic fifo_out_ready;
  assign fifo_out_ready = play_pop;

  wpb_fifo #(
    .WIDTH (2 * WORD_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clear     (flush),
    .in_data   ({rd_addr_q == wave_len - 1'b1, mem_data}),
    .in_valid  (rd_pend_q),
    .in_ready  (fifo_in_ready),
    .out_data  ({fifo_last, fifo_out_data}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  assign last_q = fifo_last;

  // --------------------------------------------------------------------
  // sample output and markers
  // --------------------------------------------------------------------
  wpb_sample_t cur_q;
  logic [3:0]  raw_mrk;
  logic [3:0]  mrk_hist_q [MAX_SHIFT];

  assign raw_mrk = {cur_q.q_word[MRK_HI_BIT], cur_q.q_word[MRK_LO_BIT],
                    cur_q.i_word[MRK_HI_BIT],
                    cur_q.i_word[MRK_LO_BIT]};

  // current sample, idle value whenever not playing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= '0;
    end else if (state_q != ST_PLAY) begin
      cur_q <= idle_value;
    end else if (play_pop && fifo_out_valid) begin
      cur_q <= fifo_out_data;
    end
  end

  // marker delay line, advances once per sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < MAX_SHIFT; k++) begin
        mrk_hist_q[k] <= '0;
      end
    end else if (samp_tick_q) begin
      mrk_hist_q[0] <= raw_mrk;
      for (int k = 1; k < MAX_SHIFT; k++) begin
        mrk_hist_q[k] <= mrk_hist_q[k-1];
      end
    end
  end

  // per marker shift selection and rear routing
  for (genvar m = 0; m < 4; m++) begin : g_mrk
    logic sel;
    assign sel = (marker_shift[m] == '0) ? raw_mrk[m]
               : mrk_hist_q[4'(marker_shift[m] - 1'b1)][m];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        marker_out[m] <= 1'b0;
      end else if (rear_routing && m >= 2) begin
        // path 3 carries Q, path 4 carries I (sign bit)
        marker_out[m] <= (m == 2) ? cur_q.q_word[WORD_W-1]
                                  : cur_q.i_word[WORD_W-1];
      end else begin
        marker_out[m] <= sel;
      end
    end
  end

  // I/Q out register, skew split between channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iq_out       <= '0;
      running      <= 1'b0;
      skew_i_steps <= '0;
      skew_q_steps <= '0;
    end else begin
      iq_out  <= cur_q;
      running <= (state_q == ST_PLAY);
      if (skew_steps > 8'(SKEW_MAX_STEPS)) begin
        skew_i_steps <= 8'(SKEW_MAX_STEPS);
        skew_q_steps <= '0;
      end else if (skew_steps < -8'(SKEW_MAX_STEPS)) begin
        skew_i_steps <= '0;
        skew_q_steps <= 8'(SKEW_MAX_STEPS);
      end else if (skew_steps >= 0) begin
        skew_i_steps <= skew_steps; // positive delays I
        skew_q_steps <= '0;
      end else begin
        skew_i_steps <= '0;
        skew_q_steps <= -skew_steps;
      end
    end
  end

  // square clock output, held low when stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_out <= 1'b0;
    end else if (state_q == ST_STOP) begin
      clock_out <= 1'b0;
    end else begin
      clock_out <= phase_q[RATE_W-1];
    end
  end

  // --------------------------------------------------------------------
  // bit error checker
  // --------------------------------------------------------------------
  logic              bclk;
  logic              bclk_prev_q;
  logic              bdat;
  logic              bval;
  logic [PRBS_W-1:0] sr_q;
  logic [4:0]        fill_q;
  logic              pred;
  logic [4:0]        deg;

  assign bclk = bclk_sync_q[1] ^ ber_clk_inv;
  assign bdat = bdat_sync_q[1] ^ ber_data_inv;
  assign bval = bval_sync_q[1] ^ ber_valid_low;

  // feedback tap per polynomial
  always_comb begin
    case (ber_poly)
      PRBS_7:  begin pred = sr_q[6]  ^ sr_q[5];  deg = 5'd7;  end
      PRBS_9:  begin pred = sr_q[8]  ^ sr_q[4];  deg = 5'd9;  end
      PRBS_15: begin pred = sr_q[14] ^ sr_q[13]; deg = 5'd15; end
      default: begin pred = sr_q[22] ^ sr_q[17]; deg = 5'd23; end
    endcase
  end

  // fill, then compare each bit against the tap prediction from received bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_prev_q   <= 1'b0;
      sr_q          <= '0;
      fill_q        <= '0;
      ber_bit_count <= '0;
      ber_err_count <= '0;
      ber_locked    <= 1'b0;
      ber_done      <= 1'b0;
    end else begin
      bclk_prev_q <= bclk;
      if (bres_sync_q[1]) begin
        fill_q        <= '0;
        ber_bit_count <= '0;
        ber_err_count <= '0;
        ber_locked    <= 1'b0;
        ber_done      <= 1'b0;
      end else if (bclk && !bclk_prev_q && bval && !ber_done) begin
        sr_q <= {sr_q[PRBS_W-2:0], bdat};
        if (fill_q < deg) begin
          fill_q <= fill_q + 5'd1;
        end else begin
          ber_locked    <= 1'b1;
          ber_bit_count <= ber_bit_count + 1'b1;
          ber_err_count <= ber_err_count + CNT_W'(bdat != pred);
          ber_done      <= (ber_bit_count + 1'b1 >= ber_int_bits);
        end
      end
    end
  end

endmodule : wpb_playback

// [verification/wpb_mem_model.sv]
/*
  Waveform memory model for the playback read port.
  Assumes data is wanted one cycle after the strobe.
*/
`timescale 1ns/1ps
module wpb_mem_model
  import wpb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  output wpb_pkg::wpb_sample_t   mem_data
);
  logic [WORD_W-1:0] i_w;
  // i word carries the address, q word its inverse
  assign i_w = {mem_addr, mem_addr[5:0]};
  // answer after one cycle, else churn
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_data <= 32'h0000_0000;
    end else if (mem_rd) begin
      mem_data <= {i_w, ~i_w};
    end else begin
      mem_data <= ~mem_data;
    end
  end
endmodule : wpb_mem_model

// [verification/wpb_playback_assertions.sv]
/*
  Assertions on the playback engine ports.
  Assumes a bind into wpb_playback.
*/
`timescale 1ns/1ps
module wpb_playback_chk
  import wpb_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire wpb_pkg::wpb_sample_t    iq_out,
  input wire wpb_pkg::wpb_sample_t    idle_value,
  input wire logic [3:0]              marker_out,
  input wire logic [4:0]              marker_shift [4],
  input wire logic                    rear_routing,
  input wire logic                    running,
  input wire logic                    clock_out,
  input wire wpb_pkg::wpb_trig_mode_t trig_mode,
  input wire logic                    cmd_trigger,
  input wire logic signed [7:0]       skew_steps,
  input wire logic signed [7:0]       skew_i_steps,
  input wire logic signed [7:0]       skew_q_steps,
  input wire logic                    checker_restart_input,
  input wire logic [CNT_W-1:0]        ber_bit_count,
  input wire logic                    ber_done
);
  logic [3:0]        still_q;
  logic              shown, plain;
  logic signed [8:0] sk_diff, sk_want;
  // stopped cycles, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      still_q <= 4'h0;
    end else if (running) begin
      still_q <= 4'h0;
    end else if (still_q != 4'hf) begin
      still_q <= still_q + 4'h1;
    end
  end
  // sample shown, markers unshifted
  assign shown = iq_out != idle_value;
  assign plain = {marker_shift[0], marker_shift[1], marker_shift[2],
                  marker_shift[3]} == 20'h0_0000;
  // skew split vs clamped target
  assign sk_diff = skew_i_steps - skew_q_steps;
  assign sk_want = skew_steps > SKEW_MAX_STEPS ? 9'(SKEW_MAX_STEPS)
                 : skew_steps < -SKEW_MAX_STEPS ? 9'(-SKEW_MAX_STEPS)
                 : 9'(skew_steps);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_marker_i_bits: assert property (
    shown && plain |-> marker_out[1:0] == iq_out.i_word[1:0])
    else $error("markers 1-2 wrong");
  chk_marker_q_bits: assert property (
    shown && plain && !rear_routing
    |-> marker_out[3:2] == iq_out.q_word[1:0])
    else $error("markers 3-4 wrong");
  chk_rear_marker_sign: assert property (
    shown && rear_routing
    |-> marker_out[3:2] == {iq_out.i_word[15], iq_out.q_word[15]})
    else $error("rear routing markers wrong");
  chk_idle_when_stopped: assert property (
    still_q >= 4'ha |-> iq_out == idle_value)
    else $error("not idle when stopped");
  chk_clock_stopped: assert property (
    still_q == 4'hf && trig_mode == TRIG_OFF |-> !clock_out)
    else $error("clock active when stopped");
  chk_off_stops: assert property (
    $rose(trig_mode == TRIG_OFF) |-> ##[1:2] !running)
    else $error("off did not stop");
  chk_no_early_start: assert property (
    $rose(cmd_trigger) && !running && trig_mode != TRIG_OFF
    |-> ##1 (iq_out == idle_value) [*8])
    else $error("early start");
  chk_skew_split: assert property (
    $stable(skew_steps) [*4] |-> sk_diff == sk_want)
    else $error("skew split wrong");
  chk_ber_hold: assert property (
    checker_restart_input [*5] |-> ber_bit_count == 0 && !ber_done)
    else $error("checker not held");

  cover property ($rose(running));
  cover property ($rose(ber_done));
  cover property (shown && rear_routing);
endmodule : wpb_playback_chk

// [verification/test_wpb_playback.sv]
/*
  Playback engine bench, FIFO reached through the top.
  Assumes package and memory model compiled first.
*/
`timescale 1ns/1ps
module test_wpb_playback;
  import wpb_pkg::*;
  // --------------------
  // signals
  // --------------------
  localparam int          LEN  = 24;
  localparam wpb_sample_t IDLE = 32'ha5a5_5a5a;
  logic clk, rst, mem_rd, cmd_trigger, fast_mode, rear_routing;
  logic ext_trigger, trig_level_sens, trig_active_low, clock_out, running;
  logic ber_clk_in, ber_data_in, bit_valid_input, checker_restart_input;
  logic ber_clk_inv, ber_data_inv, ber_valid_low, ber_locked, ber_done;
  logic [ADDR_W-1:0]  mem_addr, wave_len;
  wpb_sample_t        mem_data, idle_value, iq_out;
  wpb_trig_mode_t     trig_mode;
  wpb_prbs_sel_t      ber_poly;
  logic [RATE_W-1:0]  rate_step;
  logic signed [7:0]  skew_steps, skew_i_steps, skew_q_steps;
  logic [4:0]         marker_shift [4];
  logic [3:0]         marker_out;
  logic [CNT_W-1:0]   ber_int_bits, ber_bit_count, ber_err_count;
  int                 failures, samples_checked;
  always #10 clk = ~clk;
  wpb_playback u_wpb_playback (.*);
  wpb_mem_model u_wpb_mem_model (.*);
  // --------------------
  // tasks
  // --------------------
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  function automatic wpb_sample_t smp(int a);
    return {a[9:0], a[5:0], ~{a[9:0], a[5:0]}};
  endfunction : smp
  // n samples from address 0; sh: marker 1 one sample late
  task automatic collect(int n, logic rear, logic sh = 1'b0);
    wpb_sample_t prev, e, pe;
    int w;
    prev = iq_out;
    pe = IDLE;
    for (int k = 0; k < n; k++) begin
      w = 0;
      while (iq_out === prev && w < 100) begin
        @(posedge clk);
        #1;
        w++;
      end
      prev = iq_out;
      e = smp(k % LEN);
      check(iq_out, e);
      check(marker_out, {rear ? {e.i_word[15], e.q_word[15]} : e.q_word[1:0],
        e.i_word[1], sh ? pe.i_word[0] : e.i_word[0]});
      pe = e;
    end
  endtask : collect
  task automatic wait_idle;
    int w;
    w = 0;
    while (iq_out !== IDLE && w < 80) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(iq_out, IDLE);
  endtask : wait_idle
  task automatic trig_cmd(wpb_trig_mode_t m);
    @(posedge clk);
    trig_mode <= m;
    @(posedge clk);
    cmd_trigger <= 1'b1;
    @(posedge clk);
    cmd_trigger <= 1'b0;
  endtask : trig_cmd
  task automatic t_single;
    trig_cmd(TRIG_SINGLE);
    collect(LEN, 1'b0);
    wait_idle();
    repeat (60) @(posedge clk);
    #1;
    check(iq_out, IDLE);
    check(running, 1'b0);
    check(mem_rd, 1'b0);
  endtask : t_single
  task automatic t_repeat;
    int n;
    logic c;
    marker_shift[0] <= 5'h01;
    trig_cmd(TRIG_REPEAT);
    collect(LEN + 6, 1'b0, 1'b1);
    check(running, 1'b1);
    n = 0;
    c = clock_out;
    repeat (64) begin
      @(posedge clk);
      #1;
      n += int'(clock_out && !c);
      c = clock_out;
    end
    check(n, 16);
    @(posedge clk);
    trig_mode <= TRIG_OFF;
    repeat (4) @(posedge clk);
    #1;
    check(iq_out, IDLE);
    check(running, 1'b0);
    check(mem_rd, 1'b0);
    marker_shift[0] <= 5'h00;
  endtask : t_repeat
  task automatic t_playback_mode_a;
    @(posedge clk);
    trig_level_sens <= 1'b1;
    trig_mode <= TRIG_PLAYBACK_MODE_A;
    @(posedge clk);
    ext_trigger <= 1'b1;
    collect(LEN + 6, 1'b0);
    check(running, 1'b1);
    @(posedge clk);
    ext_trigger <= 1'b0;
    wait_idle();
    @(posedge clk);
    rear_routing <= 1'b1;
    ext_trigger <= 1'b1;
    collect(3, 1'b1);
    @(posedge clk);
    ext_trigger <= 1'b0;
    trig_mode <= TRIG_OFF;
    wait_idle();
    @(posedge clk);
    trig_level_sens <= 1'b0;
  endtask : t_playback_mode_a
  // cycles from falling trigger to first sample
  task automatic t_latency(logic fast, int lo, int hi, int hold);
    int n;
    @(posedge clk);
    fast_mode <= fast;
    trig_active_low <= 1'b1;
    ext_trigger <= 1'b1;
    repeat (4) @(posedge clk);
    trig_mode <= TRIG_SINGLE;
    repeat (4) @(posedge clk);
    ext_trigger <= 1'b0;
    n = 0;
    while (n < 200) begin
      @(posedge clk);
      if (n == hold) ext_trigger <= 1'b1;
      n++;
      #1;
      if (iq_out !== IDLE) break;
    end
    check(n >= lo && n <= hi, 1'b1);
    @(posedge clk);
    trig_mode <= TRIG_OFF;
    wait_idle();
  endtask : t_latency
  task automatic t_skew;
    int put [4] = '{50, -30, 120, -128};
    int want [4] = '{50, -30, 100, -100};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      skew_steps <= 8'(put[k]);
      repeat (6) @(posedge clk);
      #1;
      check(skew_i_steps - skew_q_steps, want[k]);
    end
  endtask : t_skew
  task automatic ber_bit(logic d, logic v);
    @(posedge clk);
    ber_data_in <= d;
    bit_valid_input <= v;
    repeat (2) @(posedge clk);
    ber_clk_in <= 1'b1;
    repeat (2) @(posedge clk);
    ber_clk_in <= 1'b0;
  endtask : ber_bit
  // PRBS7, every fifth bit invalid and wrong
  task automatic t_ber;
    logic [6:0] s;
    logic nb;
    s = 7'h7f;
    for (int k = 0; k < 180; k++) begin
      nb = s[6] ^ s[5];
      if (k == 20) checker_restart_input <= 1'b0;
      if (k % 5 == 4) begin
        ber_bit(~nb, 1'b0);
      end else begin
        s = {s[5:0], nb};
        ber_bit(nb, 1'b1);
      end
      if (k == 19) check(ber_bit_count, 0);
    end
    repeat (8) @(posedge clk);
    #1;
    check(ber_bit_count, ber_int_bits);
    check(ber_err_count, 0);
    check({ber_locked, ber_done}, 2'h3);
  endtask : t_ber
  // --------------------
  // main and watchdog
  // --------------------
  initial begin
    {clk, cmd_trigger, fast_mode, rear_routing, ext_trigger} = 5'h00;
    {trig_level_sens, trig_active_low, ber_clk_in, ber_data_in} = 4'h0;
    {bit_valid_input, ber_clk_inv, ber_data_inv, ber_valid_low} = 4'h0;
    rst = 1'b1;
    checker_restart_input = 1'b1;
    ber_poly = PRBS_7;
    wave_len = 10'h018;
    idle_value = IDLE;
    trig_mode = TRIG_OFF;
    rate_step = 32'h4000_0000;
    skew_steps = 8'h00;
    marker_shift = '{default: 5'h00};
    ber_int_bits = 32'h0000_0064;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    check(iq_out, IDLE);
    check({running, clock_out}, 2'h0);
    t_single();
    t_repeat();
    t_playback_mode_a();
    t_latency(1'b0, 11, 28, 16);
    t_latency(1'b1, 44, 60, 48);
    t_skew();
    t_ber();
    test_done();
  end
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : test_wpb_playback
bind wpb_playback wpb_playback_chk u_wpb_playback_chk (.*);
